// ### core/adc_scan_fifo_interrupt_ctrl.sv
// converter sequencer, byte-wide sample queue and threshold request behind APB
`timescale 1ns/1ns
module adc_scan_fifo_interrupt_ctrl
  import adc_ctrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // converter side
  output logic              conv_start,
  output logic [3:0]        conv_channel,
  input  wire conv_result_s conv_in,
  // trigger sources
  input  wire logic         trig_timer,
  input  wire logic         trig_external,
  // request and status
  output logic              irq_request,
  output logic              conversion_in_progress
);

  logic [7:0]  queue_mem [QUEUE_BYTES];
  seq_state_e  st_r, st_nxt;
  logic [3:0]  chan_r, chan_nxt, lo_ch, hi_ch;
  logic [7:0]  range_r, range_nxt, thresh_r, thresh_nxt;
  logic        conversion_interrupt_enable, range_sweep_enable, trigger_source_select;
  logic        deep_queue_mode;
  logic [7:0]  mode_r, mode_nxt;
  logic        deep_r, deep_nxt;
  logic [6:0]  rd_ptr_r, rd_ptr_nxt, wr_ptr_r, wr_ptr_nxt, fill_r, fill_nxt;
  logic [6:0]  depth_r, depth_nxt, pend_r, pend_nxt;
  logic        queue_overflow_flag, ovf_nxt, irq_nxt, busy_nxt, start_nxt;
  logic        pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [5:0]  idx;
  logic        mapped, acc, wr_en, rd_en, hw_trig, trig, done, push, pop, sample_queue_clear;
  logic        ovf_set, last_ch;
  logic [10:0] thr_eff;

  // bus decode: a transfer completes on the edge where pready is high
  assign idx    = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) &&
                  (idx <= IDX_DEPTH || idx == IDX_DEEP);
  assign acc    = psel && penable && pready;
  assign wr_en  = acc && pwrite && mapped;
  assign rd_en  = acc && !pwrite && mapped;

  // control fields
  assign lo_ch                       = range_r[3:0];
  assign hi_ch                       = range_r[7:4];
  assign conversion_interrupt_enable = mode_r[IRQ_EN_BIT];
  assign range_sweep_enable          = mode_r[SWEEP_BIT];
  assign trigger_source_select       = mode_r[SRC_BIT];
  assign deep_queue_mode             = deep_r;
  assign last_ch                     = (chan_r == hi_ch);

  // trigger selection: software write only while interrupts are off
  assign hw_trig = trigger_source_select ? trig_external : trig_timer;
  always_comb begin
    if (conversion_interrupt_enable) begin
      trig = hw_trig;
    end else begin
      trig = wr_en && (idx == IDX_DATA_LO);
    end
  end

  // queue events
  assign sample_queue_clear = wr_en && (idx == IDX_DATA_HI) && pwdata[CLEAR_BIT];
  assign pop  = rd_en && (idx == IDX_DATA_LO || idx == IDX_DATA_HI) && (fill_r != 7'h00);
  assign done = conv_in.done && (st_r == st_conv);
  assign ovf_set = done && ((depth_r + pend_r) >= MAX_SAMPLES);
  assign push = done && !ovf_set;

  // sequencer next state
  always_comb begin
    st_nxt    = st_r;
    chan_nxt  = chan_r;
    start_nxt = 1'b0;
    case (st_r)
      st_idle: begin
        if (trig) begin
          st_nxt    = st_conv;
          start_nxt = 1'b1;
          // a sweep always begins at the low channel, whatever single mode left
          if (range_sweep_enable) begin
            chan_nxt = lo_ch;
          end
        end
      end
      st_conv: begin
        if (done) begin
          chan_nxt = last_ch ? lo_ch : chan_r + 4'h1;
          if (range_sweep_enable && !last_ch) begin
            st_nxt = st_next;
          end else begin
            st_nxt = st_idle;
          end
        end
      end
      st_next: begin
        st_nxt    = st_conv;
        start_nxt = 1'b1;
      end
      default: st_nxt = st_idle;
    endcase
    if (wr_en && idx == IDX_RANGE) begin
      chan_nxt = pwdata[3:0];
    end
    busy_nxt = (st_nxt != st_idle);
  end

  // queue pointers, depth and flags
  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    wr_ptr_nxt = wr_ptr_r;
    fill_nxt   = fill_r;
    depth_nxt  = depth_r;
    pend_nxt   = pend_r;
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? 7'h00 : rd_ptr_r + 7'h01;
      fill_nxt   = fill_r - 7'h01;
      if (rd_ptr_r[0] && depth_r != 7'h00) begin
        depth_nxt = depth_r - 7'h01; // high byte closes a sample
      end
    end
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PTR_LAST - 7'h01) ? 7'h00 : wr_ptr_r + 7'h02;
      fill_nxt   = fill_nxt + 7'h02;
      pend_nxt   = pend_r + 7'h01;
    end
    if (st_r == st_conv && st_nxt == st_idle) begin
      depth_nxt = depth_nxt + pend_nxt;
      pend_nxt  = 7'h00;
    end
    if (sample_queue_clear) begin
      rd_ptr_nxt = 7'h00;
      wr_ptr_nxt = 7'h00;
      fill_nxt   = 7'h00;
      depth_nxt  = 7'h00;
      pend_nxt   = 7'h00;
    end
    ovf_nxt = ovf_set || (queue_overflow_flag && !sample_queue_clear);
    thr_eff = deep_queue_mode ? {thresh_r, 3'b000} : {3'b000, thresh_r};
    irq_nxt = conversion_interrupt_enable && (thr_eff != 11'h000) &&
              ({4'h0, depth_nxt} >= thr_eff);
  end

  // register writes and read data
  always_comb begin
    range_nxt   = range_r;
    mode_nxt    = mode_r;
    thresh_nxt  = thresh_r;
    deep_nxt    = deep_r;
    prdata_nxt  = prdata;
    pslverr_nxt = 1'b0;
    if (wr_en && idx == IDX_RANGE) begin
      range_nxt = pwdata[7:0];
    end else if (wr_en && idx == IDX_MODE) begin
      mode_nxt = pwdata[7:0];
    end else if (wr_en && idx == IDX_THRESH) begin
      thresh_nxt = deep_queue_mode ? pwdata[7:0] : {2'b00, pwdata[5:0]};
    end else if (wr_en && idx == IDX_DEEP) begin
      deep_nxt = pwdata[DEEP_BIT];
    end
    pready_nxt = psel && penable && !pready;
    if (pready_nxt) begin
      pslverr_nxt = !mapped;
      prdata_nxt  = 32'h0000_0000;
      if (!mapped) begin
        prdata_nxt = 32'h0000_0000;
      end else if (idx == IDX_DATA_LO || idx == IDX_DATA_HI) begin
        prdata_nxt[7:0] = queue_mem[rd_ptr_r];
      end else if (idx == IDX_RANGE) begin
        prdata_nxt[7:0] = range_r;
      end else if (idx == IDX_STATUS) begin
        prdata_nxt[BUSY_BIT] = conversion_in_progress;
        prdata_nxt[OVF_BIT]  = queue_overflow_flag;
        prdata_nxt[IRQ_BIT]  = irq_request;
      end else if (idx == IDX_MODE) begin
        prdata_nxt[7:0] = mode_r;
      end else if (idx == IDX_THRESH) begin
        prdata_nxt[7:0] = thresh_r;
      end else if (idx == IDX_DEPTH) begin
        prdata_nxt[7:0] = deep_queue_mode ? {4'h0, depth_r[6:DEEP_SHIFT]} : {1'b0, depth_r};
      end else begin
        prdata_nxt[DEEP_BIT] = deep_r;
      end
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r                   <= st_idle;
      chan_r                 <= 4'h0;
      range_r                <= RANGE_RST;
      mode_r                 <= 8'h00;
      thresh_r               <= THRESH_RST;
      deep_r                 <= 1'b0;
      rd_ptr_r               <= 7'h00;
      wr_ptr_r               <= 7'h00;
      fill_r                 <= 7'h00;
      depth_r                <= 7'h00;
      pend_r                 <= 7'h00;
      queue_overflow_flag    <= 1'b0;
      irq_request            <= 1'b0;
      conversion_in_progress <= 1'b0;
      conv_start             <= 1'b0;
      conv_channel           <= 4'h0;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      prdata                 <= 32'h0000_0000;
    end else if (ce) begin
      st_r                   <= st_nxt;
      chan_r                 <= chan_nxt;
      range_r                <= range_nxt;
      mode_r                 <= mode_nxt;
      thresh_r               <= thresh_nxt;
      deep_r                 <= deep_nxt;
      rd_ptr_r               <= rd_ptr_nxt;
      wr_ptr_r               <= wr_ptr_nxt;
      fill_r                 <= fill_nxt;
      depth_r                <= depth_nxt;
      pend_r                 <= pend_nxt;
      queue_overflow_flag    <= ovf_nxt;
      irq_request            <= irq_nxt;
      conversion_in_progress <= busy_nxt;
      conv_start             <= start_nxt;
      conv_channel           <= chan_nxt;
      pready                 <= pready_nxt;
      pslverr                <= pslverr_nxt;
      prdata                 <= prdata_nxt;
    end
  end

  // sample storage: code kept as signed two's complement bytes
  always_ff @(posedge clk) begin
    if (ce && push) begin
      queue_mem[wr_ptr_r]        <= conv_in.code[7:0];
      queue_mem[wr_ptr_r + 7'h01] <= conv_in.code[15:8];
    end
  end

  // checks
  chk_busy_follows_seq: assert property (@(posedge clk) disable iff (reset)
    ce && st_nxt != st_idle |=> conversion_in_progress)
    else $error("busy bit low during conversion");
  chk_pop_advances: assert property (@(posedge clk) disable iff (reset)
    ce && pop && !push && !sample_queue_clear |=> fill_r == $past(fill_r) - 7'h01)
    else $error("queue read did not pop a byte");
  chk_push_two_bytes: assert property (@(posedge clk) disable iff (reset)
    ce && push && !pop && !sample_queue_clear |=> fill_r == $past(fill_r) + 7'h02)
    else $error("result not stored as two bytes");
  chk_overflow_drop: assert property (@(posedge clk) disable iff (reset)
    ce && ovf_set && !pop && !sample_queue_clear |=> queue_overflow_flag && fill_r == $past(fill_r))
    else $error("overflow result not dropped");
  chk_overflow_hold: assert property (@(posedge clk) disable iff (reset)
    ce && queue_overflow_flag && !sample_queue_clear |=> queue_overflow_flag)
    else $error("overflow flag lost without clear");
  chk_clear_empties: assert property (@(posedge clk) disable iff (reset)
    ce && sample_queue_clear && !ovf_set |=> fill_r == 7'h00 && !queue_overflow_flag && !irq_request)
    else $error("clear left queue state");
  chk_irq_disabled: assert property (@(posedge clk) disable iff (reset)
    ce && !conversion_interrupt_enable && !(wr_en && idx == IDX_MODE) |=> !irq_request)
    else $error("request with interrupts disabled");
  chk_no_sw_trigger: assert property (@(posedge clk) disable iff (reset)
    ce && conversion_interrupt_enable && !hw_trig && st_r == st_idle |=> !conv_start)
    else $error("conversion started without hardware trigger");
  chk_channel_wrap: assert property (@(posedge clk) disable iff (reset)
    ce && done && last_ch && !(wr_en && idx == IDX_RANGE) |=> conv_channel == lo_ch)
    else $error("channel did not wrap to low");
  chk_sweep_next: assert property (@(posedge clk) disable iff (reset)
    ce && done && range_sweep_enable && !last_ch ##1 ce |=> conv_start)
    else $error("sweep did not continue");
  chk_irq_level: assert property (@(posedge clk) disable iff (reset)
    ce && conversion_interrupt_enable && !deep_queue_mode && thresh_r != 8'h00 &&
    {1'b0, depth_r} >= thresh_r && !pop && !sample_queue_clear && !wr_en
    |=> irq_request)
    else $error("request missing at threshold");

  cov_sweep_done: cover property (@(posedge clk) disable iff (reset)
    range_sweep_enable && st_r == st_conv && st_nxt == st_idle && pend_nxt != 7'h00);
  cov_overflow: cover property (@(posedge clk) disable iff (reset) ovf_set);
  cov_irq_rise: cover property (@(posedge clk) disable iff (reset) $rose(irq_request));

endmodule

// ### core/adc_ctrl_pkg.sv
// constants and carrier types for the converter scan and sample queue controller
package adc_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_DATA_LO = 6'h00;
  localparam logic [5:0] IDX_DATA_HI = 6'h01;
  localparam logic [5:0] IDX_RANGE   = 6'h02;
  localparam logic [5:0] IDX_STATUS  = 6'h03;
  localparam logic [5:0] IDX_MODE    = 6'h04;
  localparam logic [5:0] IDX_THRESH  = 6'h05;
  localparam logic [5:0] IDX_DEPTH   = 6'h06;
  localparam logic [5:0] IDX_DEEP    = 6'h0c;
  // field positions
  localparam int CLEAR_BIT    = 4;  // queue clear in the high-data register write
  localparam int BUSY_BIT     = 7;  // status: conversion in progress
  localparam int OVF_BIT      = 6;  // status: queue overflow
  localparam int IRQ_BIT      = 5;  // status: threshold request
  localparam int IRQ_EN_BIT   = 0;  // mode: conversion interrupt enable
  localparam int SWEEP_BIT    = 1;  // mode: range sweep enable
  localparam int SRC_BIT      = 4;  // mode: trigger source select
  localparam int DEEP_BIT     = 0;
  localparam int DEEP_SHIFT   = 3;  // deep mode drops the low 3 bits: threshold is the top 8 of 11, depth reads the top 4 of 7
  // queue geometry
  localparam int              QUEUE_BYTES = 96;
  localparam logic [6:0]      MAX_SAMPLES = 7'h30;  // 48 samples
  localparam logic [6:0]      PTR_LAST    = 7'h5f;
  // reset values
  localparam logic [7:0]      RANGE_RST   = 8'h00;
  localparam logic [7:0]      THRESH_RST  = 8'h00;

  typedef enum logic [1:0] {st_idle, st_conv, st_next} seq_state_e;

  // result from the converter: one-cycle done strobe with signed code
  typedef struct packed {
    logic        done;
    logic [15:0] code;
  } conv_result_s;
endpackage

// ### tb/conv_model.sv
// converter stand-in: answers each start after a set latency with a channel-coded result
`timescale 1ns/1ns
module conv_model
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // converter side
  input  wire logic         conv_start,
  input  wire logic [3:0]   conv_channel,
  input  wire logic [3:0]   lat,
  output conv_result_s      conv_in
);
  logic [3:0] cnt;
  logic       run;
  logic [3:0] ch;

  // latency countdown; the code toggles while idle so a stale value never looks valid
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      run <= 1'b0;
      cnt <= 4'h0;
      ch <= 4'h0;
      conv_in <= '0;
    end else begin
      if (conv_start) begin
        run <= 1'b1;
        cnt <= lat;
        ch <= conv_channel;
        conv_in <= '{1'b0, ~conv_in.code};
      end else if (run && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        conv_in <= '{1'b0, ~conv_in.code};
      end else if (run) begin
        run <= 1'b0;
        conv_in <= '{1'b1, {ch[0], 3'h5, ch, ~ch, ch}};  // odd channels give negative codes
      end else begin
        conv_in <= '{1'b0, ~conv_in.code};
      end
    end
  end
endmodule

// ### tb/adc_scan_fifo_interrupt_ctrl_test.sv
// register-level bench for the converter sequencer and sample queue
`timescale 1ns/1ns
module adc_scan_fifo_interrupt_ctrl_test
  import adc_ctrl_pkg::*;
;
  logic         clk, reset, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr, v;
  logic [31:0]  pwdata, prdata;
  logic         conv_start, trig_timer, trig_external, irq_request, conversion_in_progress;
  logic [3:0]   conv_channel, lat;
  conv_result_s conv_in;
  logic         err_seen;
  int           errors, checks, cyc, i;

  adc_scan_fifo_interrupt_ctrl u_dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_in(conv_in), .trig_timer(trig_timer), .trig_external(trig_external),
    .irq_request(irq_request), .conversion_in_progress(conversion_in_progress));

  conv_model u_conv (.clk(clk), .reset(reset), .conv_start(conv_start),
    .conv_channel(conv_channel), .lat(lat), .conv_in(conv_in));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask

  // one apb transfer: hold everything until pready is seen high at an edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd_v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata[7:0];
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] junk;
    apb(1'b1, idx, d, junk);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] d);
    apb(1'b0, idx, 8'h00, d);
  endtask

  // low byte then high byte of one result
  task automatic rdsmp(input logic [3:0] ch);
    logic [7:0] lo, hi;
    rd(IDX_DATA_LO, lo);
    rd(IDX_DATA_HI, hi);
    chk({hi, lo}, {ch[0], 3'h5, ch, ~ch, ch});
  endtask

  // polled host: wait for busy low before touching the queue
  task automatic wait_idle();
    do rd(IDX_STATUS, v); while (v[BUSY_BIT] !== 1'b0);
  endtask

  task automatic trig(input logic ext);
    if (ext) trig_external <= 1'b1;
    else trig_timer <= 1'b1;
    @(posedge clk);
    trig_timer <= 1'b0;
    trig_external <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, trig_timer, trig_external} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h2;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped index
    rd(IDX_RANGE, v);
    chk(v, RANGE_RST);
    chkb(err_seen, 1'b0);
    rd(IDX_THRESH, v);
    chk(v, THRESH_RST);
    rd(6'h07, v);
    chkb(err_seen, 1'b1);
    // single software conversions step and wrap through channels 1..2
    wr(IDX_RANGE, 8'h21);
    for (i = 0; i < 3; i++) begin
      wr(IDX_DATA_LO, 8'h00);
      wait_idle();
    end
    rd(IDX_DEPTH, v);
    chk(v, 8'h03);
    rdsmp(4'h1);
    rdsmp(4'h2);
    rdsmp(4'h1);
    rd(IDX_DEPTH, v);
    chk(v, 8'h00);
    // slow sweep over channels 0..3: busy throughout, depth published at the end
    lat <= 4'h9;
    wr(IDX_MODE, 8'h02);
    wr(IDX_RANGE, 8'h30);
    wr(IDX_DATA_LO, 8'h00);
    for (i = 0; i < 6; i++) begin
      rd(IDX_STATUS, v);
      chkb(v[BUSY_BIT], 1'b1);
      chkb(conversion_in_progress, 1'b1);
    end
    rd(IDX_DEPTH, v);
    chk(v, 8'h00);
    wait_idle();
    rd(IDX_DEPTH, v);
    chk(v, 8'h04);
    for (i = 0; i < 4; i++) rdsmp(i[3:0]);
    // interrupt mode: software and unselected triggers start nothing
    lat <= 4'h1;
    wr(IDX_RANGE, 8'h55);
    chk({12'h000, conv_channel}, 16'h0005);
    wr(IDX_THRESH, 8'h02);
    wr(IDX_MODE, 8'h01);
    wr(IDX_DATA_LO, 8'h00);
    trig(1'b1);
    wait_idle();
    rd(IDX_DEPTH, v);
    chk(v, 8'h00);
    trig(1'b0);
    wait_idle();
    chkb(irq_request, 1'b0);
    trig(1'b0);
    wait_idle();
    chkb(irq_request, 1'b1);
    wr(IDX_MODE, 8'h11);
    trig(1'b1);
    wait_idle();
    rd(IDX_DEPTH, v);
    chk(v, 8'h03);
    rdsmp(4'h5);
    chkb(irq_request, 1'b1);
    rdsmp(4'h5);
    chkb(irq_request, 1'b0);
    // a trigger while the clock enable is low must leave everything frozen
    ce <= 1'b0;
    trig(1'b1);
    ce <= 1'b1;
    rd(IDX_DEPTH, v);
    chk(v, 8'h01);
    trig(1'b1);
    wait_idle();
    wr(IDX_DATA_HI, 8'h10);
    chkb(irq_request, 1'b0);
    rd(IDX_DEPTH, v);
    chk(v, 8'h00);
    // sweep with interrupts: threshold of one whole sweep of two channels
    wr(IDX_RANGE, 8'h10);
    wr(IDX_THRESH, 8'h02);
    wr(IDX_MODE, 8'h03);
    trig(1'b0);
    wait_idle();
    chkb(irq_request, 1'b1);
    rdsmp(4'h0);
    rdsmp(4'h1);
    chkb(irq_request, 1'b0);
    wr(IDX_RANGE, 8'h55);
    // interrupts off: fill to 48, then one more overflows
    wr(IDX_MODE, 8'h00);
    for (i = 0; i < 48; i++) begin
      wr(IDX_DATA_LO, 8'h00);
      wait_idle();
    end
    chk(v & 8'he0, 8'h00);
    wr(IDX_DATA_LO, 8'h00);
    wait_idle();
    chk(v & 8'he0, 8'h40);
    rd(IDX_DEPTH, v);
    chk(v, 8'h30);
    wr(IDX_DEEP, 8'h01);
    rd(IDX_DEPTH, v);
    chk(v, 8'h06);
    wr(IDX_DEEP, 8'h00);
    rdsmp(4'h5);
    wr(IDX_DATA_LO, 8'h00);
    wait_idle();
    chk(v & 8'he0, 8'h40);
    wr(IDX_DATA_HI, 8'h10);
    rd(IDX_STATUS, v);
    chk(v & 8'he0, 8'h00);
    summarize();
  end
endmodule
